// ==== include/sdcct_cfg.svh ====
/*
  Cycle figures and field positions of the SDRAM command timing core.
  Assumes one rising-edge clock shared with the controller; all timing figures are clock cycles.
*/
`ifndef SDCCT_CFG_SVH
`define SDCCT_CFG_SVH
// column read latency and derived activate-to-data latency
`define SDCCT_CL 3
`define SDCCT_RCD 3
`define SDCCT_RAC 6
// spacing the controller keeps (fastest grade / slower grades)
`define SDCCT_RC_FAST 10
`define SDCCT_RC_SLOW 9
`define SDCCT_RAS_FAST 7
`define SDCCT_RAS_SLOW 6
`define SDCCT_RP 3
`define SDCCT_RRD 2
`define SDCCT_CCD 1
`define SDCCT_DPL 2
`define SDCCT_DAL 5
`define SDCCT_MRD 2
// data-side delays kept by the device
`define SDCCT_RBD 3
`define SDCCT_WBD 0
`define SDCCT_RAL 3
`define SDCCT_WDL 0
`define SDCCT_PQL (-2)
`define SDCCT_QMD 2
`define SDCCT_DMD 0
// address fields
`define SDCCT_AP_BIT 10
`define SDCCT_BL_LSB 0
`define SDCCT_BL_RST 4
`endif

// ==== include/sdcct_pkg.sv ====
/*
  Types of the SDRAM command timing core: command pins, decoded operations, burst states.
  Assumes the command pins are sampled on the same clock as the core.
*/
package sdcct_pkg;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdcct_cmd_t;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0, OP_ACT = 3'h1, OP_RD = 3'h2, OP_WR = 3'h3,
    OP_BST = 3'h4, OP_PRE = 3'h5, OP_REF = 3'h6, OP_MRS = 3'h7
  } sdcct_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_READ = 2'b01, ST_WRITE = 2'b10
  } sdcct_st_t;

  // deselect and the all-high pattern both mean no operation
  function automatic sdcct_op_t sdcct_decode(input sdcct_cmd_t c);
    sdcct_op_t op;
    op = OP_NOP;
    if (!c.cs_n) begin
      case ({c.ras_n, c.cas_n, c.we_n})
        3'b011: op = OP_ACT;
        3'b101: op = OP_RD;
        3'b100: op = OP_WR;
        3'b110: op = OP_BST;
        3'b010: op = OP_PRE;
        3'b001: op = OP_REF;
        3'b000: op = OP_MRS;
        default: op = OP_NOP;
      endcase
    end
    return op;
  endfunction
endpackage

// ==== rtl/sdcct_bank.sv ====
/*
  One bank's open/closed state with a delayed self-close for auto-closing bursts.
  Assumes act, pre and arm are one-cycle pulses from the core on the same clock.
*/
`timescale 1ns/1ps
module sdcct_bank #(
  parameter int DLY_W = 3
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_act,
  input wire logic i_pre,
  input wire logic i_arm,
  input wire logic [DLY_W-1:0] i_arm_dly,
  output logic o_open
);
  logic [DLY_W-1:0] cnt_r;

  // countdown: the bank closes on the i_arm_dly-th edge after the arm
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else if (i_arm) begin
      cnt_r <= i_arm_dly;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // an explicit close or a finished countdown wins over nothing else pending
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_open <= 1'b0;
    end else if (i_act) begin
      o_open <= 1'b1;
    end else if (i_pre || (cnt_r == DLY_W'(1) && !i_arm)) begin
      o_open <= 1'b0;
    end
  end
endmodule

// ==== rtl/sdcct_core.sv ====
/*
  Device-side command timing core of a quad-bank SDRAM at read latency three:
  command decode, burst sequencing, read pipeline, data mask, burst stop,
  precharge truncation, auto-close and a small column-only data store.
  Assumes command pins come from logic on the same clock, so no synchronisers.
*/
`timescale 1ns/1ps
`include "sdcct_cfg.svh"

module sdcct_core import sdcct_pkg::*; #(
  parameter int DW = 16,
  parameter int AW = 13,
  parameter int COL_W = 4,
  parameter int CL = `SDCCT_CL
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire sdcct_cmd_t i_cmd,
  input wire logic [1:0] i_ba,
  input wire logic [AW-1:0] i_addr,
  input wire logic i_dqm,
  input wire logic [DW-1:0] i_dq,
  output logic [DW-1:0] o_dq,
  output logic o_dq_oe,
  output logic [3:0] o_bank_open,
  output logic [COL_W:0] o_burst_len
);
  localparam int IW = COL_W + 2;
  // self-close delays: read closes CL+offset after last issue, write after recovery
  localparam logic [2:0] RD_AC_DLY = 3'(`SDCCT_CL + `SDCCT_PQL);
  localparam logic [2:0] WR_AC_DLY = 3'(`SDCCT_DPL);

  sdcct_op_t op;
  sdcct_st_t st_r;
  logic [1:0] bank_r;
  logic [COL_W-1:0] col_r;
  logic [COL_W:0] left_r;
  logic [COL_W:0] bl_r;
  logic ac_r;
  logic dqm_r;
  logic [DW-1:0] mem [2**IW];
  logic [DW-1:0] pd_r [CL];
  logic [CL-1:0] pv_r;
  logic is_rd, is_wr, is_col, tgt_hit, stop, cont;
  logic rd_word, wr_word, wr_en, last_w, ac_now, ac_fire, rd_side;
  logic [1:0] w_bank;
  logic [COL_W-1:0] w_col;
  logic [IW-1:0] w_idx;
  logic [3:0] w_onehot;

  assign op = sdcct_decode(i_cmd);
  assign is_rd = (op == OP_RD);
  assign is_wr = (op == OP_WR);
  assign is_col = is_rd | is_wr;

  // stop and a precharge of the burst's bank or of all banks end the burst in the cycle they arrive
  assign tgt_hit = (i_ba == bank_r) | i_addr[`SDCCT_AP_BIT];
  assign stop = (op == OP_BST) | ((op == OP_PRE) & tgt_hit);
  assign cont = (st_r != ST_IDLE) & !is_col & !stop;

  // a new column command always takes over from the running burst
  assign w_bank = is_col ? i_ba : bank_r;
  assign w_col = is_col ? i_addr[COL_W-1:0] : col_r;
  assign w_idx = {w_bank, w_col};
  assign w_onehot = 4'h1 << w_bank;
  assign rd_word = is_rd | (cont & (st_r == ST_READ));
  assign wr_word = is_wr | (cont & (st_r == ST_WRITE));
  // write mask acts with no latency
  assign wr_en = wr_word & !i_dqm;

  // word issued this edge is the burst's last one
  assign last_w = (is_col & (bl_r == (COL_W+1)'(1))) | (cont & (left_r == (COL_W+1)'(1)));
  assign ac_now = is_col ? i_addr[`SDCCT_AP_BIT] : ac_r;
  assign ac_fire = last_w & ac_now;
  assign rd_side = is_col ? is_rd : (st_r == ST_READ);

  // burst sequencer; linear column walk, no wrap at burst boundary
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= ST_IDLE;
      bank_r <= 2'h0;
      col_r <= '0;
      left_r <= '0;
      ac_r <= 1'b0;
    end else if (is_col) begin
      bank_r <= i_ba;
      col_r <= COL_W'(i_addr[COL_W-1:0] + 1'b1);
      left_r <= bl_r - 1'b1;
      ac_r <= i_addr[`SDCCT_AP_BIT];
      if (bl_r == (COL_W+1)'(1)) begin
        st_r <= ST_IDLE;
      end else begin
        st_r <= is_rd ? ST_READ : ST_WRITE;
      end
    end else if (stop) begin
      st_r <= ST_IDLE;
    end else if (cont) begin
      col_r <= col_r + 1'b1;
      left_r <= left_r - 1'b1;
      if (left_r == (COL_W+1)'(1)) begin
        st_r <= ST_IDLE;
      end
    end
  end

  // burst length from the mode set; full page uses the whole modelled row
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bl_r <= (COL_W+1)'(`SDCCT_BL_RST);
    end else if (op == OP_MRS) begin
      case (i_addr[`SDCCT_BL_LSB +: 3])
        3'h0: bl_r <= (COL_W+1)'(1);
        3'h1: bl_r <= (COL_W+1)'(2);
        3'h2: bl_r <= (COL_W+1)'(4);
        3'h3: bl_r <= (COL_W+1)'(8);
        default: bl_r <= (COL_W+1)'(2**COL_W);
      endcase
    end
  end
  assign o_burst_len = bl_r;

  // data store; rows alias onto one column set per bank to stay small
  always_ff @(posedge i_clk) begin
    if (wr_en) begin
      mem[w_idx] <= i_dq;
    end
  end

  // read mask sampled here gates the word loaded into the output next edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dqm_r <= 1'b0;
    end else begin
      dqm_r <= i_dqm;
    end
  end

  // CL-deep pipeline, last stage is the pin register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pv_r <= '0;
    end else begin
      pv_r[0] <= rd_word;
      for (int i = 1; i < CL - 1; i++) begin
        pv_r[i] <= pv_r[i-1];
      end
      pv_r[CL-1] <= pv_r[CL-2] & !dqm_r;
    end
  end

  // pipeline data carries no reset; validity alone decides the drive
  always_ff @(posedge i_clk) begin
    pd_r[0] <= mem[w_idx];
    for (int i = 1; i < CL; i++) begin
      pd_r[i] <= pd_r[i-1];
    end
  end
  assign o_dq = pd_r[CL-1];
  assign o_dq_oe = pv_r[CL-1];

  // per-bank state with self-close after the last word
  for (genvar b = 0; b < 4; b++) begin : g_bank
    sdcct_bank #(
      .DLY_W(3)
    ) u_bank (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_act((op == OP_ACT) && (i_ba == 2'(b))),
      .i_pre((op == OP_PRE) && ((i_ba == 2'(b)) || i_addr[`SDCCT_AP_BIT])),
      .i_arm(ac_fire && (w_bank == 2'(b))),
      .i_arm_dly(rd_side ? RD_AC_DLY : WR_AC_DLY),
      .o_open(o_bank_open[b])
    );
  end

  rd_lat_a:
  assert property (@(posedge i_clk) disable iff (!i_rst_n) is_rd ##1 !i_dqm |-> ##2 o_dq_oe)
    else $error("read data not driven three cycles after read");

  act_rd_a:
  assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (op == OP_ACT) ##3 is_rd ##1 !i_dqm |-> ##2 o_dq_oe)
    else $error("read data not driven six cycles after activate");

  ccd_rd_a:
  assert property (@(posedge i_clk) disable iff (!i_rst_n)
    is_rd ##1 (is_rd && !i_dqm) ##1 !i_dqm |-> ##1 o_dq_oe [*2])
    else $error("consecutive reads did not both produce data");

  bst_rd_a:
  assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r == ST_READ) && (op == OP_BST) |-> ##3 !o_dq_oe)
    else $error("outputs still driven three cycles after burst stop");

  pre_rd_a:
  assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r == ST_READ) && (op == OP_PRE) && tgt_hit |-> ##3 !o_dq_oe)
    else $error("outputs still driven three cycles after precharge");

  bst_wr_a:
  assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r == ST_WRITE) && (op == OP_BST) |-> !wr_en ##1 (is_wr || !wr_en))
    else $error("write data taken after burst stop");

  pre_wr_a:
  assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r == ST_WRITE) && (op == OP_PRE) && tgt_hit |-> !wr_en ##1 (is_wr || !wr_en))
    else $error("write data taken after precharge");

  dqm_rd_a:
  assert property (@(posedge i_clk) disable iff (!i_rst_n) i_dqm |-> ##2 !o_dq_oe)
    else $error("read mask did not float output two cycles later");

  dqm_wr_a:
  assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_word && i_dqm |=> mem[$past(w_idx)] == $past(mem[w_idx]))
    else $error("masked write word stored");

  ac_rd_a:
  assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ac_fire && rd_side && !(op == OP_ACT) ##1 (op != OP_ACT) |->
    ##1 ((o_bank_open & $past(w_onehot, 2)) == 4'h0))
    else $error("bank not closing two cycles before last read word");
endmodule

// ==== verification/sdcct_ctl_model.sv ====
/*
  Controller model for the command timing core: one command a cycle, each held back
  by no-operation cycles until the per-bank and device-wide spacings allow it.
  Assumes the core samples these pins on the same rising edge.
*/
`timescale 1ns/1ps
`include "sdcct_cfg.svh"
module sdcct_ctl_model import sdcct_pkg::*; (
  input wire logic i_clk,
  output sdcct_cmd_t o_cmd,
  output logic [1:0] o_ba,
  output logic [12:0] o_addr,
  output logic o_dqm,
  output logic [15:0] o_dq
);
  int cyc = 0;
  int any_act = -99;
  int mrs_t = -99;
  int ref_t = -99;
  logic [1:0] wb = 2'b00;
  int act_t[4] = '{default: -99};
  int pre_t[4] = '{default: -99};
  int wr_end[4] = '{default: -99};

  // pins idle (deselect) at time zero
  initial begin
    o_cmd = 4'hf;
    o_ba = 2'h0;
    o_addr = 13'h0000;
    o_dqm = 1'b0;
    o_dq = 16'h0000;
  end

  function automatic int mx(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // pins change just after an edge and stand one full cycle
  task automatic drv(input logic [2:0] k, input logic [1:0] b, input logic [12:0] a, input logic m,
                     input logic [15:0] d);
    @(posedge i_clk);
    cyc++;
    o_cmd <= {1'b0, k};
    o_ba <= b;
    o_addr <= a;
    o_dqm <= m;
    o_dq <= d;
  endtask

  // write data is valid only on write edges; elsewhere the line keeps toggling
  task automatic issue(input logic [2:0] k, input logic [1:0] b, input logic [12:0] a, input logic m,
                       input logic [15:0] d);
    int t;
    t = mrs_t + `SDCCT_MRD;
    if (k == 3'b011) t = mx(mx(t, act_t[b] + `SDCCT_RC_FAST), mx(pre_t[b] + `SDCCT_RP, any_act + `SDCCT_RRD));
    if (k == 3'b011) t = mx(t, wr_end[b] + `SDCCT_DAL);
    // refresh spacing, counted over all banks
    if (k == 3'b001) t = mx(t, ref_t + `SDCCT_RC_FAST);
    if (k == 3'b001) t = mx(t, mx(mx(wr_end[0], wr_end[1]), mx(wr_end[2], wr_end[3])) + `SDCCT_DAL);
    if (k[2:1] == 2'b10) t = mx(t, act_t[b] + `SDCCT_RCD);
    if (k == 3'b010) t = mx(t, mx(act_t[b] + `SDCCT_RAS_FAST, wr_end[b] + `SDCCT_DPL));
    while (cyc + 1 < t) drv(3'b111, b, 13'h0000, 1'b0, ~o_dq);
    drv(k, b, a, m, (k == 3'b100) ? d : ~o_dq);
    if (k == 3'b011) act_t[b] = cyc;
    if (k == 3'b011) any_act = cyc;
    if (k == 3'b010) pre_t[b] = cyc;
    if (k == 3'b000) mrs_t = cyc;
    if (k == 3'b001) ref_t = cyc;
    if (k == 3'b100) wb = b;
    if (k == 3'b100 && !m) wr_end[b] = cyc;
  endtask

  // later words of a write burst; a masked word does not count as written data
  task automatic dat(input logic m, input logic [15:0] d);
    drv(3'b111, wb, 13'h0000, m, d);
    if (!m) wr_end[wb] = cyc;
  endtask
endmodule

// ==== verification/sdcct_core_tb.sv ====
/*
  Self-checking bench of the command timing core: the controller model drives the pins
  and the mode and read tasks judge burst length, read data and bank flags; the write task checks nothing.
  Assumes a 200 MHz clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`define TB_CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module sdcct_core_tb import sdcct_pkg::*;;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  sdcct_cmd_t cmd;
  logic [1:0] ba;
  logic [12:0] addr;
  logic dqm;
  logic [15:0] wdat;
  logic [15:0] rdat;
  logic oe;
  logic [3:0] bopen;
  logic [4:0] blen;
  logic [9:0] flags;
  logic [15:0] mem [4][16];
  int failures = 0;
  int checks_done = 0;
  int bl = 8;

  assign flags = {oe, bopen, blen};

  // 5 ns period
  always #2.5 i_clk = ~i_clk;

  sdcct_ctl_model ctl_u (.i_clk(i_clk), .o_cmd(cmd), .o_ba(ba), .o_addr(addr), .o_dqm(dqm), .o_dq(wdat));
  sdcct_core dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd(cmd), .i_ba(ba), .i_addr(addr), .i_dqm(dqm),
    .i_dq(wdat), .o_dq(rdat), .o_dq_oe(oe), .o_bank_open(bopen), .o_burst_len(blen));

  task automatic op(input logic [2:0] k, input logic [1:0] b, input logic [12:0] a, input logic m);
    ctl_u.issue(k, b, a, m, 16'h0000);
  endtask

  // burst length codes, ending at eight words
  task automatic modes();
    int code[5] = '{0, 1, 2, 7, 3};
    int len[5] = '{1, 2, 4, 16, 8};
    for (int i = 0; i < 5; i++) begin
      op(3'b000, 2'b00, 13'(code[i]), 1'b0);
      op(3'b111, 2'b00, 13'h0000, 1'b0);
      #1;
      `TB_CHK("burst length", 5'(len[i]), blen)
    end
  endtask

  // write burst; word mj masked, stop command sk at step sj drops that word and the rest
  task automatic wr(input logic [1:0] b, input int col, input int mj, input int sj, input logic [2:0] sk,
                    input logic [15:0] s);
    ctl_u.issue(3'b100, b, 13'(col), mj == 0, s);
    for (int j = 0; j < bl && j != sj; j++) begin
      if (j > 0) ctl_u.dat(j == mj, s + 16'(j));
      if (j != mj) mem[b][(col + j) % 16] = s + 16'(j);
    end
    if (sj < bl) op(sk, b, 13'h0000, 1'b0);
  endtask

  // read burst with mask at step mj and stop command at step sj; every output cycle judged
  task automatic rd(input logic [1:0] b, input int col, input logic ap, input int mj, input int sj,
                    input logic [2:0] sk);
    int lim;
    int c;
    lim = (sj < bl) ? ((sk == 3'b101) ? sj + bl : sj) : bl;
    op(3'b101, b, {2'b00, ap, 10'(col)}, 1'b0);
    for (int j = 1; j <= lim + 4; j++) begin
      op((j == sj) ? sk : 3'b111, b, 13'h0000, j == mj);
      #1;
      c = (sk == 3'b101 && j - 3 >= sj) ? j - 3 - sj : col + j - 3;
      `TB_CHK("drive enable", (j >= 3 && j - 3 < lim && j != mj + 2), oe)
      if (j >= 3 && j - 3 < lim && j != mj + 2) `TB_CHK("read data", mem[b][c % 16], rdat)
      if (ap && (j == bl || j == bl + 1)) `TB_CHK("bank open", j == bl, bopen[b])
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    report_and_stop();
  end

  // main sequence: reset, modes, fill three banks, then cut, masked and auto-closing bursts
  initial begin
    repeat (5) @(posedge i_clk);
    `TB_CHK("reset flags", 10'h004, flags)
    i_rst_n <= 1'b1;
    modes();
    for (int b = 0; b < 3; b++) op(3'b011, 2'(b), 13'h0000, 1'b0);
    for (int b = 0; b < 6; b++) wr(2'(b / 2), (b % 2) * 8, -9, 99, 3'b111, 16'((b << 12) + b));
    wr(2'b10, 4, 2, 3, 3'b010, 16'h0a00);
    op(3'b011, 2'b10, 13'h0000, 1'b0);
    rd(2'b10, 4, 1'b0, -9, 99, 3'b111);
    rd(2'b00, 2, 1'b0, -9, 1, 3'b101);
    rd(2'b00, 0, 1'b0, 2, 99, 3'b111);
    rd(2'b01, 3, 1'b0, -9, 2, 3'b110);
    wr(2'b01, 0, -9, 3, 3'b110, 16'h0b00);
    rd(2'b00, 5, 1'b0, -9, 1, 3'b010);
    rd(2'b01, 0, 1'b1, -9, 99, 3'b111);
    `TB_CHK("bank flags", 4'h4, bopen)
    // close every bank at once, then refresh, which must leave the flags alone
    op(3'b010, 2'b10, 13'h0400, 1'b0);
    op(3'b001, 2'b00, 13'h0000, 1'b0);
    op(3'b111, 2'b00, 13'h0000, 1'b0);
    #1;
    `TB_CHK("bank flags after refresh", 4'h0, bopen)
    report_and_stop();
  end
endmodule
